// ==== tvr_regs.vh ====
// Constants of the trip value recorder
`ifndef TVR_REGS_VH
`define TVR_REGS_VH
`define TVR_CLK_HZ          40000000
`define TVR_SAMPLE_HZ       1000
`define TVR_PRE_MS          100
`define TVR_F1_MS           10
`define TVR_F2_MS           20
`define TVR_DIV_CYC         (`TVR_CLK_HZ / `TVR_SAMPLE_HZ)
`define TVR_PRE_SMP         ((`TVR_PRE_MS * `TVR_SAMPLE_HZ) / 1000)
`define TVR_F1_SMP          ((`TVR_F1_MS * `TVR_SAMPLE_HZ) / 1000)
`define TVR_F2_SMP          ((`TVR_F2_MS * `TVR_SAMPLE_HZ) / 1000)
`define TVR_HIST_DEPTH      128
`define TVR_HIST_AW         7
`define TVR_DW              16
`define TVR_PW              32
`define TVR_NCH             3
`define TVR_KIND_PRE        1'b0
`define TVR_KIND_FAULT      1'b1
`endif

// ==== tvr_trip_value_recorder.v ====
// Trip value recorder: prefault and fault capture with event reporting
`timescale 1ns/10ps
`include "tvr_regs.vh"
// Functional notes
// - A rising start edge latches prefault and fault values of all three channels, then waits for trip.
// - A new start edge before any trip replaces the latched values with fresh ones.
// - Trip emits the latched values as events toward the event list and supervisory control.
// - The prefault value is the channel sample taken 100 ms before the start edge.
// - The fault value is the mean of the samples 10 ms and 20 ms after the start edge.
// - Secondary inputs are scaled to primary values before capture and reporting.
// - Each channel yields one prefault event and one fault event in the unit of its input.
// - The recorder has no settings; offsets and behaviour are fixed.
// - The recorder drives no binary outputs; events are its only outputs.
module tvr_trip_value_recorder (
    // Clock and reset
    input  wire                     ref_clk_i,
    input  wire                     reset_n_i,
    // Secondary measurements and fixed transformer ratios
    input  wire [`TVR_DW-1:0]       ch0_sec_i,
    input  wire [`TVR_DW-1:0]       ch1_sec_i,
    input  wire [`TVR_DW-1:0]       ch2_sec_i,
    input  wire [`TVR_DW-1:0]       ch0_ratio_i,
    input  wire [`TVR_DW-1:0]       ch1_ratio_i,
    input  wire [`TVR_DW-1:0]       ch2_ratio_i,
    // Protection logic
    input  wire                     start_capture_in_i,
    input  wire                     trip_trigger_in_i,
    // Event output, the only outputs of the block
    output reg                      evt_valid_o,
    output reg  [1:0]               evt_chan_o,
    output reg                      evt_kind_o,
    output reg  [`TVR_PW-1:0]       evt_value_o,
    input  wire                     evt_ready_i
);
    // ******************************
    // Fixed timing and report states
    // ******************************
    // Offsets are built in; the block has nothing that software can adjust
    localparam [31:0] DIV_LAST = `TVR_DIV_CYC - 1;
    localparam [31:0] PRE_OFF  = `TVR_PRE_SMP;
    localparam [31:0] F1_LAST  = `TVR_F1_SMP - 1;
    localparam [31:0] F2_LAST  = `TVR_F2_SMP - 1;
    // One-hot report states
    localparam        ST_IDLE  = 2'b01;
    localparam        ST_SEND  = 2'b10;

    // ******************************
    // Sampling tick and scaling
    // ******************************
    reg  [15:0]               div_cnt;
    wire                      tick = (div_cnt == 16'h0000);
    wire [3*`TVR_DW-1:0]      sec_bus = {ch2_sec_i, ch1_sec_i, ch0_sec_i};
    wire [3*`TVR_DW-1:0]      rat_bus = {ch2_ratio_i, ch1_ratio_i, ch0_ratio_i};

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt <= 16'h0000;
        end else if (tick) begin
            div_cnt <= DIV_LAST[15:0];
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    // ******************************
    // History and capture per channel
    // ******************************
    reg  [`TVR_HIST_AW-1:0]   wr_ptr;
    reg                       start_d;
    reg  [4:0]                smp_cnt;
    reg                       pending;
    reg                       armed;
    reg  [1:0]                state;
    reg  [2:0]                idx;
    reg                       trip_seen;
    wire                      start_edge = start_capture_in_i & ~start_d;
    // Restart wins over a report about to begin
    wire                      fire = (state == ST_IDLE) && trip_seen && armed &&
                                     !pending && !start_edge;
    wire [`TVR_HIST_AW-1:0]   pre_addr = wr_ptr - PRE_OFF[`TVR_HIST_AW-1:0];
    // Latched values of all channels, packed so that the report can index them
    wire [3*`TVR_PW-1:0]      pre_bus;
    wire [3*`TVR_PW-1:0]      flt_bus;

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= {`TVR_HIST_AW{1'b0}};
        end else if (tick) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `TVR_NCH; g = g + 1) begin : g_ch
            reg [`TVR_PW-1:0] hist [0:`TVR_HIST_DEPTH-1];
            wire [`TVR_PW-1:0] p = sec_bus[g*`TVR_DW +: `TVR_DW] *
                                   rat_bus[g*`TVR_DW +: `TVR_DW];
            reg  [`TVR_PW-1:0] pre_r;
            reg  [`TVR_PW-1:0] f1_r;
            reg  [`TVR_PW-1:0] flt_r;
            // One extra bit keeps the carry so the mean never wraps
            wire [`TVR_PW:0]   sum = {1'b0, f1_r} + {1'b0, p};
            assign pre_bus[g*`TVR_PW +: `TVR_PW] = pre_r;
            assign flt_bus[g*`TVR_PW +: `TVR_PW] = flt_r;
            // History is not reset: prefault reads before 100 ticks are undefined
            always @(posedge ref_clk_i) begin
                if (tick) begin
                    hist[wr_ptr] <= p;
                end
            end
            always @(posedge ref_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pre_r <= {`TVR_PW{1'b0}};
                    f1_r  <= {`TVR_PW{1'b0}};
                    flt_r <= {`TVR_PW{1'b0}};
                end else begin
                    if (start_edge) begin
                        pre_r <= hist[pre_addr];
                    end
                    if (pending && tick && smp_cnt == F1_LAST[4:0]) begin
                        f1_r <= p;
                    end
                    if (pending && tick && smp_cnt == F2_LAST[4:0]) begin
                        flt_r <= sum[`TVR_PW:1];
                    end
                end
            end
        end
    endgenerate

    // ******************************
    // Capture sequencing
    // ******************************
    // A trip during the 20 ms fault window waits until the fault mean exists
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_d <= 1'b0;
            smp_cnt <= 5'h00;
            pending <= 1'b0;
            armed   <= 1'b0;
        end else begin
            start_d <= start_capture_in_i;
            if (start_edge) begin
                smp_cnt <= 5'h00;
                pending <= 1'b1;
                armed   <= 1'b1;
            end else if (pending && tick) begin
                smp_cnt <= smp_cnt + 5'h01;
                // The window closes on the tick that takes the second fault sample
                if (smp_cnt == F2_LAST[4:0]) begin
                    pending <= 1'b0;
                end
            end else if (fire) begin
                armed <= 1'b0;
            end
        end
    end

    // ******************************
    // Event emission
    // ******************************
    // Word order: channel 0 prefault, channel 0 fault, then channels 1 and 2
    wire [1:0]          nch     = idx[2:1];
    wire [`TVR_PW-1:0]  pre_sel = pre_bus[nch*`TVR_PW +: `TVR_PW];
    wire [`TVR_PW-1:0]  flt_sel = flt_bus[nch*`TVR_PW +: `TVR_PW];

    // ******************************
    // Report sequencing
    // ******************************

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state       <= ST_IDLE;
            idx         <= 3'h0;
            trip_seen   <= 1'b0;
            evt_valid_o <= 1'b0;
            evt_chan_o  <= 2'h0;
            evt_kind_o  <= `TVR_KIND_PRE;
            evt_value_o <= {`TVR_PW{1'b0}};
        end else begin
            // A trip without a latched capture is dropped, not remembered
            if (trip_trigger_in_i && armed) begin
                trip_seen <= 1'b1;
            end else if (!armed) begin
                trip_seen <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (fire) begin
                        trip_seen <= 1'b0;
                        idx       <= 3'h0;
                        state     <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (!evt_valid_o || evt_ready_i) begin
                        if (idx == 3'h6) begin
                            evt_valid_o <= 1'b0;
                            state       <= ST_IDLE;
                        end else begin
                            evt_valid_o <= 1'b1;
                            evt_chan_o  <= nch;
                            evt_kind_o  <= idx[0];
                            if (idx[0]) begin
                                evt_value_o <= flt_sel;
                            end else begin
                                evt_value_o <= pre_sel;
                            end
                            idx         <= idx + 3'h1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // tvr_trip_value_recorder

// ==== tvr_checker_asserts.sv ====
// Checker of the recorder event stream
`timescale 1ns/10ps
module tvr_checker (
    // Clock, reset, start and event port
    input wire        ref_clk_i,
    input wire        reset_n_i,
    input wire        start_capture_in_i,
    input wire        evt_valid_o,
    input wire [1:0]  evt_chan_o,
    input wire        evt_kind_o,
    input wire [31:0] evt_value_o,
    input wire        evt_ready_i
);
    reg        sq, arm;
    reg [23:0] age;
    wire       rise = start_capture_in_i && !sq;
    wire       take = evt_valid_o && evt_ready_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Age saturates so that no stale start looks fresh
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) {sq, arm, age} <= {2'h0, 24'hFFFFFF};
        else {sq, arm, age} <= {start_capture_in_i, rise || (arm && !evt_valid_o),
                                rise ? 24'h0 : age + {23'h0, age != 24'hFFFFFF}};
    end
    hold_evt_a: assert property (evt_valid_o && !evt_ready_i |=> evt_valid_o &&
        $stable({evt_chan_o, evt_kind_o, evt_value_o})) else $error("stalled event moved");
    chan_range_a: assert property (evt_valid_o |-> evt_chan_o < 2'h3)
        else $error("channel out of range");
    first_evt_a: assert property ($rose(evt_valid_o) |-> evt_chan_o == 2'h0 && !evt_kind_o)
        else $error("report opens wrongly");
    kind_step_a: assert property (take && !evt_kind_o |=> evt_valid_o && evt_kind_o &&
        evt_chan_o == $past(evt_chan_o)) else $error("prefault without fault");
    chan_step_a: assert property (take && evt_kind_o && evt_chan_o < 2'h2 |=> evt_valid_o &&
        !evt_kind_o && evt_chan_o == $past(evt_chan_o) + 2'h1) else $error("channel order");
    last_evt_a: assert property (take && evt_kind_o && evt_chan_o == 2'h2 |=> !evt_valid_o)
        else $error("event after last fault");
    armed_a: assert property ($rose(evt_valid_o) |-> arm) else $error("report without start");
    window_a: assert property ($rose(evt_valid_o) |-> age >= 24'hB98C0)
        else $error("report before fault window");
endmodule // tvr_checker

// ==== tvr_event_sink.sv ====
// Event list model that stalls every other cycle
`timescale 1ns/10ps
module tvr_event_sink (
    // Clock and event port
    input  wire        ref_clk_i,
    input  wire        evt_valid_i,
    input  wire [1:0]  evt_chan_i,
    input  wire        evt_kind_i,
    input  wire [31:0] evt_value_i,
    output reg         evt_ready_o
);
    reg [34:0] log [0:15];
    integer    n = 0;
    initial evt_ready_o = 1'b0;
    // Toggling ready forces every event after the first of a report to wait and hold once
    always @(negedge ref_clk_i) evt_ready_o <= ~evt_ready_o;
    always @(posedge ref_clk_i) if (evt_valid_i && evt_ready_o) begin
        log[n[3:0]] <= {evt_chan_i, evt_kind_i, evt_value_i};
        n <= n + 1;
    end
endmodule // tvr_event_sink

// ==== tvr_trip_value_recorder_bench.sv ====
// Self-checking testbench of the trip value recorder
`timescale 1ns/10ps
module tvr_trip_value_recorder_bench;
    reg         ref_clk_i = 1'b0, reset_n_i = 1'b0, start = 1'b0, trip = 1'b0;
    reg  [15:0] base = 16'h2;
    wire        vld, knd, rdy;
    wire [1:0]  chn;
    wire [31:0] val;
    integer     cyc = 0, failures = 0, cmp_count = 0, i;
    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (reset_n_i) cyc <= cyc + 1;
    // Samples step every eighth tick, so a one-tick sampling slip reads the same value
    always @(negedge ref_clk_i) base <= cyc / 320000 * 8 + 2;
    tvr_trip_value_recorder tvr_trip_value_recorder_inst (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .ch0_sec_i(base), .ch1_sec_i(base + 16'h1),
        .ch2_sec_i(base + 16'h2), .ch0_ratio_i(16'h3), .ch1_ratio_i(16'h5),
        .ch2_ratio_i(16'h7), .start_capture_in_i(start), .trip_trigger_in_i(trip),
        .evt_valid_o(vld), .evt_chan_o(chn), .evt_kind_o(knd), .evt_value_o(val),
        .evt_ready_i(rdy));
    tvr_event_sink tvr_event_sink_inst (.ref_clk_i(ref_clk_i), .evt_valid_i(vld),
        .evt_chan_i(chn), .evt_kind_i(knd), .evt_value_i(val), .evt_ready_o(rdy));
    task check(input [63:0] name, input [34:0] seen, input [34:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task go_to(input integer c); while (cyc < c) @(negedge ref_clk_i); endtask
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task test_idle_trip;
        go_to(200000);
        trip = 1'b1;
        go_to(200400);
        trip = 1'b0;
        check("events", tvr_event_sink_inst.n, 0);
        $display("test_idle_trip done");
    endtask
    // Second start replaces the first; trip lands inside the fault window
    task test_restart_report;
        go_to(2420000);
        start = 1'b1;
        go_to(2420010);
        start = 1'b0;
        go_to(4460000);
        start = 1'b1;
        go_to(4600000);
        trip = 1'b1;
        go_to(4600010);
        {start, trip} = 2'h0;
        go_to(5300000);
        for (i = 0; i < 6; i = i + 1)
            check("event", tvr_event_sink_inst.log[i], {i[2:1], i[0], 32'((3 + i / 2 * 2) * (i % 2 ? 126 + i / 2 : 10 + i / 2))});
        trip = 1'b1;
        go_to(5300400);
        trip = 1'b0;
        check("count", tvr_event_sink_inst.n, 6);
        $display("test_restart_report done");
    endtask
    initial begin
        repeat (20) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        test_idle_trip;
        test_restart_report;
        end_of_test;
    end
    initial begin
        #150000000;
        failures = failures + 1;
        end_of_test;
    end
endmodule // tvr_trip_value_recorder_bench
bind tvr_trip_value_recorder tvr_checker tvr_checker_inst (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .start_capture_in_i(start_capture_in_i), .evt_valid_o(evt_valid_o),
    .evt_chan_o(evt_chan_o), .evt_kind_o(evt_kind_o), .evt_value_o(evt_value_o),
    .evt_ready_i(evt_ready_i));
